/* File: rtl/cmr_core.sv */
// Purpose: accumulator/file datapath for or, move, rotate, no-op and return ops
// Assumes: classic wishbone slave on ref_clk, synchronous active-high reset
// Notes: one instruction cycle is one ref_clk cycle
// Notes: bus writes while an instruction runs are acked and dropped
// Notes: file memory and stack contents are not reset
// Notes on behaviour
// - literal or: acc or literal into acc, only zero flag changes
// - load literal: literal into acc, no flag changes
// - file or: acc or file register, routed by destination, only zero changes
// - destination bit 0 writes acc, 1 writes the addressed file register
// - store acc: acc copied into addressed file register, flags untouched
// - copy file: value moved to destination, zero set from it, even to itself
// - interrupt return: pc from stack top, interrupt enable set, flags untouched
// - rotate left through carry, routed by destination, only carry changes
// - rotate right through carry, routed by destination, only carry changes
// - return with literal: literal into acc, pc from stack top, flags untouched
// - return with literal takes two instruction cycles
// - every return pops the stack top entry it loaded, except on an empty stack, where the depth stays 0
//
// Decided for this implementation: the Wishbone register port and the address map.
`default_nettype none
`include "cmr_defs.svh"
module cmr_core (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [12:0] program_counter,
  output logic global_interrupt_enable,
  output logic stack_pop_pulse
);

  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction : is_zero

  function automatic logic is_return(input cmr_pkg::cmr_op_t o);
    return o == cmr_pkg::interrupt_return_op || o == cmr_pkg::return_with_literal_op;
  endfunction : is_return

  function automatic logic [8:0] rotate_thru(
    input logic [7:0] v,
    input logic c,
    input logic left
  );
    if (left) begin
      return {v[7], v[6:0], c};
    end
    return {v[0], c, v[7:1]};
  endfunction : rotate_thru

  cmr_pkg::cmr_state_t state_r, state_nxt;
  logic [12:0] cmd_r, cmd_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic carry_r, carry_nxt;
  logic zero_r, zero_nxt;
  logic gie_r, gie_nxt;
  logic [12:0] pc_r, pc_nxt;
  logic [3:0] sp_r, sp_nxt;
  logic [6:0] faddr_r, faddr_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic pop_r, pop_nxt;
  logic [12:0] stack_mem [0:7];
  logic [7:0] file_mem [0:127];
  logic stk_we;
  logic [2:0] stk_idx;
  logic [12:0] stk_data;
  logic fm_we;
  logic [6:0] fm_addr;
  logic [7:0] fm_data;

  logic req;
  logic bus_wr;
  logic idle;
  logic [31:0] wmerge;
  logic [31:0] status_word;
  cmr_pkg::cmr_op_t op;
  logic [7:0] operand;
  logic dest;
  logic [6:0] f_addr;
  logic [7:0] f_val;
  logic [2:0] top_idx;
  logic [12:0] top_val;
  logic [7:0] result;
  logic route;

  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign bus_wr = req & wb_we_i;
  assign idle = state_r == cmr_pkg::cmr_idle;
  assign op = cmr_pkg::cmr_op_t'(cmd_r[`CMR_CMD_OP_MSB:`CMR_CMD_OP_LSB]);
  assign operand = cmd_r[`CMR_CMD_OPND_MSB:0];
  assign dest = cmd_r[`CMR_CMD_DEST_BIT];
  assign f_addr = cmd_r[6:0];
  assign f_val = file_mem[f_addr];
  assign top_idx = 3'(sp_r - 4'h1);
  assign top_val = stack_mem[top_idx];

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`CMR_ST_CARRY] = carry_r;
    status_word[`CMR_ST_ZERO] = zero_r;
    status_word[`CMR_ST_GIE] = gie_r;
    status_word[`CMR_ST_BUSY] = ~idle;
  end

  // bus slave: ack one cycle after the request, read data registered
  always_comb begin
    ack_nxt = req;
    dat_nxt = 32'h0000_0000;
    wmerge = 32'h0000_0000;
    if (req && !wb_we_i) begin
      if (wb_adr_i == `CMR_ADR_CMD) begin
        dat_nxt = {19'h00000, cmd_r};
      end else if (wb_adr_i == `CMR_ADR_ACC) begin
        dat_nxt = {24'h000000, acc_r};
      end else if (wb_adr_i == `CMR_ADR_STATUS) begin
        dat_nxt = status_word;
      end else if (wb_adr_i == `CMR_ADR_PC) begin
        dat_nxt = {19'h00000, pc_r};
      end else if (wb_adr_i == `CMR_ADR_STACK) begin
        dat_nxt = {19'h00000, top_val};
        dat_nxt[`CMR_STK_DEPTH_MSB:`CMR_STK_DEPTH_LSB] = sp_r;
      end else if (wb_adr_i == `CMR_ADR_FADDR) begin
        dat_nxt = {25'h0000000, faddr_r};
      end else if (wb_adr_i == `CMR_ADR_FDATA) begin
        dat_nxt = {24'h000000, file_mem[faddr_r]};
      end else begin
        dat_nxt = 32'h0000_0000;
      end
    end
    if (bus_wr) begin
      wmerge = wb_dat_i;
    end
  end

  always_comb begin
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    acc_nxt = acc_r;
    carry_nxt = carry_r;
    zero_nxt = zero_r;
    gie_nxt = gie_r;
    pc_nxt = pc_r;
    sp_nxt = sp_r;
    faddr_nxt = faddr_r;
    pop_nxt = 1'b0;
    stk_we = 1'b0;
    stk_idx = sp_r[2:0];
    stk_data = 13'h0000;
    fm_we = 1'b0;
    fm_addr = f_addr;
    fm_data = 8'h00;
    result = 8'h00;
    route = 1'b0;
    case (state_r)
      cmr_pkg::cmr_idle: begin
        if (bus_wr) begin
          if (wb_adr_i == `CMR_ADR_CMD) begin
            cmd_nxt = 13'(merge_bytes({19'h00000, cmd_r}, wmerge, wb_sel_i));
            state_nxt = cmr_pkg::cmr_exec;
          end else if (wb_adr_i == `CMR_ADR_ACC) begin
            acc_nxt = 8'(merge_bytes({24'h000000, acc_r}, wmerge, wb_sel_i));
          end else if (wb_adr_i == `CMR_ADR_STATUS) begin
            if (wb_sel_i[0]) begin
              carry_nxt = wmerge[`CMR_ST_CARRY];
              zero_nxt = wmerge[`CMR_ST_ZERO];
              gie_nxt = wmerge[`CMR_ST_GIE];
            end
          end else if (wb_adr_i == `CMR_ADR_PC) begin
            pc_nxt = 13'(merge_bytes({19'h00000, pc_r}, wmerge, wb_sel_i));
          end else if (wb_adr_i == `CMR_ADR_STACK) begin
            if (sp_r != `CMR_STACK_LEVELS) begin
              stk_we = 1'b1;
              stk_data = wmerge[12:0];
              sp_nxt = sp_r + 4'h1;
            end
          end else if (wb_adr_i == `CMR_ADR_FADDR) begin
            if (wb_sel_i[0]) begin
              faddr_nxt = wmerge[6:0];
            end
          end else if (wb_adr_i == `CMR_ADR_FDATA) begin
            if (wb_sel_i[0]) begin
              fm_we = 1'b1;
              fm_addr = faddr_r;
              fm_data = wmerge[7:0];
            end
          end
        end
      end
      cmr_pkg::cmr_exec: begin
        state_nxt = cmr_pkg::cmr_idle;
        pc_nxt = pc_r + 13'h0001;
        case (op)
          cmr_pkg::or_literal_into_acc: begin
            acc_nxt = acc_r | operand;
            zero_nxt = is_zero(acc_r | operand);
          end
          cmr_pkg::load_literal_into_acc: begin
            acc_nxt = operand;
          end
          cmr_pkg::or_acc_with_file: begin
            result = acc_r | f_val;
            route = 1'b1;
            zero_nxt = is_zero(acc_r | f_val);
          end
          cmr_pkg::store_acc_to_file: begin
            fm_we = 1'b1;
            fm_data = acc_r;
          end
          cmr_pkg::copy_file_value: begin
            result = f_val;
            route = 1'b1;
            zero_nxt = is_zero(f_val);
          end
          cmr_pkg::interrupt_return_op: begin
            pc_nxt = top_val;
            gie_nxt = 1'b1;
          end
          cmr_pkg::rotate_left_carry_op: begin
            {carry_nxt, result} = rotate_thru(f_val, carry_r, 1'b1);
            route = 1'b1;
          end
          cmr_pkg::rotate_right_carry_op: begin
            {carry_nxt, result} = rotate_thru(f_val, carry_r, 1'b0);
            route = 1'b1;
          end
          cmr_pkg::return_with_literal_op: begin
            acc_nxt = operand;
            pc_nxt = top_val;
          end
          default: begin
            pc_nxt = pc_r + 13'h0001;
          end
        endcase
        if (is_return(op)) begin
          state_nxt = cmr_pkg::cmr_second;
        end
        if (is_return(op)) begin
          pop_nxt = 1'b1;
          if (sp_r != 4'h0) begin
            sp_nxt = sp_r - 4'h1;
          end
        end
        if (route) begin
          if (dest) begin
            fm_we = 1'b1;
            fm_data = result;
          end else begin
            acc_nxt = result;
          end
        end
      end
      cmr_pkg::cmr_second: begin
        state_nxt = cmr_pkg::cmr_idle;
      end
      default: begin
        state_nxt = cmr_pkg::cmr_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= cmr_pkg::cmr_idle;
      cmd_r <= 13'h0000;
      acc_r <= `CMR_ACC_RESET;
      carry_r <= 1'b0;
      zero_r <= 1'b0;
      gie_r <= 1'b0;
      pc_r <= `CMR_PC_RESET;
      sp_r <= 4'h0;
      faddr_r <= 7'h00;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      pop_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      acc_r <= acc_nxt;
      carry_r <= carry_nxt;
      zero_r <= zero_nxt;
      gie_r <= gie_nxt;
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      faddr_r <= faddr_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      pop_r <= pop_nxt;
    end
  end

  // return stack array, no reset
  always_ff @(posedge ref_clk) begin
    if (stk_we) begin
      stack_mem[stk_idx] <= stk_data;
    end
  end

  // file register array, no reset
  always_ff @(posedge ref_clk) begin
    if (fm_we) begin
      file_mem[fm_addr] <= fm_data;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign program_counter = pc_r;
  assign global_interrupt_enable = gie_r;
  assign stack_pop_pulse = pop_r;

endmodule : cmr_core
`default_nettype wire

/* File: rtl/cmr_defs.svh */
// Purpose: offsets, fields, reset values and codes for the move/rotate/return datapath
// Assumes: byte addresses on an 8-bit wishbone address
// Notes: definitions only
`ifndef CMR_DEFS_SVH
`define CMR_DEFS_SVH
`define CMR_ADR_CMD 8'h00
`define CMR_ADR_ACC 8'h04
`define CMR_ADR_STATUS 8'h08
`define CMR_ADR_PC 8'h0c
`define CMR_ADR_STACK 8'h10
`define CMR_ADR_FADDR 8'h14
`define CMR_ADR_FDATA 8'h18
`define CMR_CMD_OPND_MSB 7
`define CMR_CMD_DEST_BIT 8
`define CMR_CMD_OP_LSB 9
`define CMR_CMD_OP_MSB 12
`define CMR_ST_CARRY 0
`define CMR_ST_ZERO 1
`define CMR_ST_GIE 2
`define CMR_ST_BUSY 3
`define CMR_STK_DEPTH_LSB 16
`define CMR_STK_DEPTH_MSB 19
`define CMR_STACK_LEVELS 4'h8
`define CMR_ACC_RESET 8'h00
`define CMR_PC_RESET 13'h0000
`define CMR_OP_NOP 4'h0
`define CMR_OP_OR_LIT 4'h1
`define CMR_OP_LOAD_LIT 4'h2
`define CMR_OP_OR_FILE 4'h3
`define CMR_OP_STORE_ACC 4'h4
`define CMR_OP_COPY_FILE 4'h5
`define CMR_OP_INT_RETURN 4'h6
`define CMR_OP_ROT_LEFT 4'h7
`define CMR_OP_ROT_RIGHT 4'h8
`define CMR_OP_RET_LIT 4'h9
`endif

/* File: rtl/cmr_pkg.sv */
// Purpose: types for the move/rotate/return datapath
// Assumes: cmr_defs.svh supplies the codes
// Notes: none
`default_nettype none
`include "cmr_defs.svh"
package cmr_pkg;
  typedef enum logic [3:0] {
    no_operation_op = `CMR_OP_NOP,
    or_literal_into_acc = `CMR_OP_OR_LIT,
    load_literal_into_acc = `CMR_OP_LOAD_LIT,
    or_acc_with_file = `CMR_OP_OR_FILE,
    store_acc_to_file = `CMR_OP_STORE_ACC,
    copy_file_value = `CMR_OP_COPY_FILE,
    interrupt_return_op = `CMR_OP_INT_RETURN,
    rotate_left_carry_op = `CMR_OP_ROT_LEFT,
    rotate_right_carry_op = `CMR_OP_ROT_RIGHT,
    return_with_literal_op = `CMR_OP_RET_LIT
  } cmr_op_t;
  typedef enum logic [2:0] {
    cmr_idle = 3'b001,
    cmr_exec = 3'b010,
    cmr_second = 3'b100
  } cmr_state_t;
endpackage : cmr_pkg
`default_nettype wire

/* File: verification/cmr_core_bench.sv */
// Purpose: self-checking bench for cmr_core
// Assumes: wishbone access, one cycle ack
// Notes: directed tests only
`default_nettype none
`include "cmr_defs.svh"
module cmr_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [12:0] program_counter, epc;
  logic global_interrupt_enable, stack_pop_pulse;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  int pops = 0;
  cmr_core cmr_core_inst (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .program_counter(program_counter), .global_interrupt_enable(global_interrupt_enable),
    .stack_pop_pulse(stack_pop_pulse));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (stack_pop_pulse === 1'b1) pops <= pops + 1;
    if (cycles == 4000) begin
      err_total = err_total + 1;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_sel_i <= 4'hf;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) @(posedge ref_clk);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge ref_clk);
  endtask : xfer
  task automatic rchk(input logic [7:0] adr, input logic [31:0] exp, input string nm);
    xfer(1'b0, adr, 32'h0);
    chk(nm, rd, exp);
  endtask : rchk
  task automatic exec(input cmr_pkg::cmr_op_t op, input logic d, input logic [7:0] k);
    xfer(1'b1, `CMR_ADR_CMD, {19'h0, op, d, k});
    epc = epc + 13'h1;
    do xfer(1'b0, `CMR_ADR_STATUS, 32'h0); while (rd[3] !== 1'b0);
  endtask : exec
  initial begin
    reset <= 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= '0;
    wb_sel_i <= 4'hf;
    epc = 13'h0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rchk(`CMR_ADR_ACC, 32'h0, "acc");
    rchk(`CMR_ADR_STATUS, 32'h0, "status");
    rchk(8'h1c, 32'h0, "unmapped");
    $display("test reset done");
    xfer(1'b1, `CMR_ADR_STATUS, 32'h3);
    exec(cmr_pkg::load_literal_into_acc, 1'b0, 8'ha5);
    rchk(`CMR_ADR_ACC, 32'ha5, "acc");
    rchk(`CMR_ADR_STATUS, 32'h3, "status");
    exec(cmr_pkg::or_literal_into_acc, 1'b0, 8'h5a);
    rchk(`CMR_ADR_ACC, 32'hff, "acc");
    rchk(`CMR_ADR_STATUS, 32'h1, "status");
    exec(cmr_pkg::load_literal_into_acc, 1'b0, 8'h00);
    exec(cmr_pkg::or_literal_into_acc, 1'b0, 8'h00);
    rchk(`CMR_ADR_STATUS, 32'h3, "status");
    $display("test literal done");
    exec(cmr_pkg::load_literal_into_acc, 1'b0, 8'h81);
    exec(cmr_pkg::store_acc_to_file, 1'b0, 8'h7f);
    xfer(1'b1, `CMR_ADR_FADDR, 32'h7f);
    rchk(`CMR_ADR_FDATA, 32'h81, "file");
    rchk(`CMR_ADR_STATUS, 32'h3, "status");
    exec(cmr_pkg::load_literal_into_acc, 1'b0, 8'h00);
    exec(cmr_pkg::copy_file_value, 1'b0, 8'h7f);
    rchk(`CMR_ADR_ACC, 32'h81, "acc");
    rchk(`CMR_ADR_STATUS, 32'h1, "status");
    xfer(1'b1, `CMR_ADR_FADDR, 32'h10);
    xfer(1'b1, `CMR_ADR_FDATA, 32'h0);
    exec(cmr_pkg::copy_file_value, 1'b1, 8'h10);
    rchk(`CMR_ADR_STATUS, 32'h3, "status");
    rchk(`CMR_ADR_FDATA, 32'h0, "file");
    $display("test move done");
    xfer(1'b1, `CMR_ADR_FDATA, 32'h06);
    exec(cmr_pkg::or_acc_with_file, 1'b1, 8'h10);
    rchk(`CMR_ADR_FDATA, 32'h87, "file");
    rchk(`CMR_ADR_ACC, 32'h81, "acc");
    exec(cmr_pkg::or_acc_with_file, 1'b0, 8'h10);
    rchk(`CMR_ADR_ACC, 32'h87, "acc");
    rchk(`CMR_ADR_STATUS, 32'h1, "status");
    $display("test or file done");
    xfer(1'b1, `CMR_ADR_FDATA, 32'h80);
    xfer(1'b1, `CMR_ADR_STATUS, 32'h2);
    exec(cmr_pkg::rotate_left_carry_op, 1'b0, 8'h10);
    rchk(`CMR_ADR_ACC, 32'h0, "acc");
    rchk(`CMR_ADR_STATUS, 32'h3, "status");
    exec(cmr_pkg::rotate_right_carry_op, 1'b1, 8'h10);
    rchk(`CMR_ADR_FDATA, 32'hc0, "file");
    rchk(`CMR_ADR_STATUS, 32'h2, "status");
    $display("test rotate done");
    xfer(1'b1, `CMR_ADR_PC, 32'h1ffe);
    epc = 13'h1ffe;
    exec(cmr_pkg::no_operation_op, 1'b0, 8'h00);
    exec(cmr_pkg::no_operation_op, 1'b0, 8'h00);
    chk("pc", {19'h0, program_counter}, {19'h0, epc});
    rchk(`CMR_ADR_STATUS, 32'h2, "status");
    rchk(`CMR_ADR_ACC, 32'h0, "acc");
    $display("test no-op done");
    xfer(1'b1, `CMR_ADR_STACK, 32'h0123);
    xfer(1'b1, `CMR_ADR_STACK, 32'h00aa);
    rchk(`CMR_ADR_STACK, 32'h0002_00aa, "stack");
    exec(cmr_pkg::interrupt_return_op, 1'b0, 8'h00);
    chk("pc", {19'h0, program_counter}, 32'h00aa);
    chk("enable", {31'h0, global_interrupt_enable}, 32'h1);
    rchk(`CMR_ADR_STATUS, 32'h6, "status");
    rchk(`CMR_ADR_STACK, 32'h0001_0123, "stack");
    exec(cmr_pkg::return_with_literal_op, 1'b0, 8'h3c);
    chk("pc", {19'h0, program_counter}, 32'h0123);
    rchk(`CMR_ADR_ACC, 32'h3c, "acc");
    rchk(`CMR_ADR_STATUS, 32'h6, "status");
    chk("pops", pops, 32'h2);
    $display("test return done");
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk("pc", {19'h0, program_counter}, 32'h0);
    chk("enable", {31'h0, global_interrupt_enable}, 32'h0);
    rchk(`CMR_ADR_ACC, 32'h0, "acc");
    rchk(`CMR_ADR_STATUS, 32'h0, "status");
    $display("test mid reset done");
    print_verdict();
  end
endmodule : cmr_core_bench
`default_nettype wire

/* File: verification/cmr_core_properties.sv */
// Purpose: port checker for cmr_core
// Assumes: one cycle ack, master holds request until ack
// Notes: bound to cmr_core below
`default_nettype none
`include "cmr_defs.svh"
module cmr_core_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [12:0] program_counter,
  input wire logic global_interrupt_enable,
  input wire logic stack_pop_pulse
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  logic [1:0] busy_cnt_r;
  // shadow of instruction busy time, two cycles for returns
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy_cnt_r <= 2'h0;
    end else if (busy_cnt_r != 2'h0) begin
      busy_cnt_r <= busy_cnt_r - 2'h1;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
      && wb_adr_i == `CMR_ADR_CMD) begin
      busy_cnt_r <= (wb_dat_i[12:9] == 4'h6 || wb_dat_i[12:9] == 4'h9) ? 2'h2 : 2'h1;
    end
  end
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_pop_pulse;
    stack_pop_pulse |=> !stack_pop_pulse;
  endproperty
  a_pop_pulse: assert property (p_pop_pulse) else $error("pop too long");
  property p_pop_cause;
    stack_pop_pulse |-> $past(wb_ack_o && wb_we_i && wb_adr_i == `CMR_ADR_CMD
      && (wb_dat_i[12:9] == 4'h6 || wb_dat_i[12:9] == 4'h9));
  endproperty
  a_pop_cause: assert property (p_pop_cause) else $error("pop without return");
  property p_gie_rise;
    $rose(global_interrupt_enable) |-> stack_pop_pulse || $past(wb_cyc_i && wb_stb_i
      && wb_we_i && wb_adr_i == `CMR_ADR_STATUS && wb_sel_i[0] && wb_dat_i[2]);
  endproperty
  a_gie_rise: assert property (p_gie_rise) else $error("enable set unasked");
  property p_gie_ret;
    stack_pop_pulse && $past(wb_dat_i[12:9]) == 4'h6 |-> global_interrupt_enable;
  endproperty
  a_gie_ret: assert property (p_gie_ret) else $error("enable not set");
  property p_pc_write;
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == `CMR_ADR_PC
      && wb_sel_i == 4'hf && busy_cnt_r == 2'h0 |=> program_counter == $past(wb_dat_i[12:0]);
  endproperty
  a_pc_write: assert property (p_pc_write) else $error("pc write lost");
  property p_ret_second;
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == `CMR_ADR_CMD
      && wb_sel_i == 4'hf && busy_cnt_r == 2'h0
      && (wb_dat_i[12:9] == 4'h6 || wb_dat_i[12:9] == 4'h9)
      |=> !stack_pop_pulse ##1 stack_pop_pulse;
  endproperty
  a_ret_second: assert property (p_ret_second) else $error("return not two cycles");
  property p_reset;
    disable iff (1'b0) reset |=> !wb_ack_o && program_counter == 13'h0
      && !global_interrupt_enable && !stack_pop_pulse;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
endmodule : cmr_core_checker
bind cmr_core cmr_core_checker cmr_core_checker_inst (.ref_clk(ref_clk), .reset(reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .program_counter(program_counter), .global_interrupt_enable(global_interrupt_enable),
  .stack_pop_pulse(stack_pop_pulse));
`default_nettype wire
